// File: rtl/fsp_pkg.sv
package fsp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FSP_CMD_OFS    = 8'h00;
  localparam logic [7:0] FSP_ADDR_OFS   = 8'h04;
  localparam logic [7:0] FSP_DATA_OFS   = 8'h08;
  localparam logic [7:0] FSP_SEL_OFS    = 8'h0c;
  localparam logic [7:0] FSP_PROT_OFS   = 8'h10;
  localparam logic [7:0] FSP_STAT_OFS   = 8'h14;
  localparam logic [7:0] FSP_RDADR_OFS  = 8'h18;
  localparam logic [7:0] FSP_RDDAT_OFS  = 8'h1c;
  localparam logic [7:0] FSP_LIMIT_OFS  = 8'h20;

  // ----------------------------------------------------------------
  // command codes written to the command register
  // ----------------------------------------------------------------
  localparam logic [2:0] FSP_CMD_PROG    = 3'h1;
  localparam logic [2:0] FSP_CMD_ERASE   = 3'h2;
  localparam logic [2:0] FSP_CMD_CHIP    = 3'h3;
  localparam logic [2:0] FSP_CMD_SUSPEND = 3'h4;
  localparam logic [2:0] FSP_CMD_RESUME  = 3'h5;
  localparam logic [2:0] FSP_CMD_RESET   = 3'h6;

  // ----------------------------------------------------------------
  // status byte positions and reset values
  // ----------------------------------------------------------------
  localparam int FSP_CPOL_POS  = 7;
  localparam int FSP_BTOG_POS  = 6;
  localparam int FSP_TOUT_POS  = 5;
  localparam int FSP_STOG_POS  = 2;
  localparam logic [7:0]  FSP_ERASED    = 8'hff;
  localparam logic [15:0] FSP_LIMIT_RST = 16'h0100;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FSP_CLK_KHZ       = 10000;
  localparam int FSP_PROT_PROG_NS  = 1000;
  localparam int FSP_PROT_ERASE_US = 100;
  localparam int FSP_PROT_PROG_CYC  = FSP_PROT_PROG_NS * FSP_CLK_KHZ / 1000000;
  localparam int FSP_PROT_ERASE_CYC = FSP_PROT_ERASE_US * FSP_CLK_KHZ / 1000;
  localparam int FSP_PULSE_CYC     = 4;

  typedef enum logic [2:0] {
    FSP_IDLE, FSP_PROG, FSP_ERASE, FSP_SUSP, FSP_SUSP_PROG, FSP_PROT, FSP_FAIL
  } fsp_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } fsp_op_t;

endpackage : fsp_pkg

// File: rtl/fsp_status.sv
// Behaviour
// RQ1 - program shows inverted written bit seven
// RQ2 - status valid from command acceptance edge
// RQ3 - host polls the programmed address
// RQ4 - protected program: polarity busy 1us, no write
// RQ5 - erase shows zero, then one after
// RQ6 - host polls inside selected sectors
// RQ7 - polarity may resolve before low bits
// RQ8 - host rereads polarity after timeout bit
// RQ9 - bank toggle inverts each read while busy
// RQ10 - bank toggle readable anywhere in bank
// RQ11 - each status read counts as one cycle
// RQ12 - all protected erase toggles 100us
// RQ13 - partially protected erase skips protected sectors
// RQ14 - bank toggle stops on erase suspend
// RQ15 - protected program toggles 1us then data
// RQ16 - suspend program toggles until done
// RQ17 - sector toggle only on selected sectors
// RQ18 - suspended unselected sectors return array data
// RQ19 - host compares two consecutive reads
// RQ20 - host rechecks after timeout, then resets
// RQ21 - host restarts algorithm after pausing
// RQ22 - timeout bit set past pulse limit
// RQ23 - busy bank reads return status byte
module fsp_status
  import fsp_pkg::*;
#(
  parameter int SECTORS   = 8,
  parameter int PROT_ERASE_CYC = FSP_PROT_ERASE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int SW = $clog2(SECTORS);
  localparam int CW = 16;

  fsp_state_t              st_q;
  fsp_op_t                 op_q;
  logic [SECTORS-1:0]      sel_q;
  logic [SECTORS-1:0]      prot_q;
  logic [CW-1:0]           cnt_q;
  logic [CW-1:0]           limit_q;
  logic                    btog_q;
  logic                    stog_q;
  logic                    tout_q;
  logic [7:0]              mem_q [256];
  logic [7:0]              rdadr_q;
  logic [7:0]              rddat_q;
  logic [7:0]              last_q;
  logic                    prot_pg_q;

  logic                    aw_q;
  logic                    w_q;
  logic [7:0]              awa_q;
  logic [31:0]             wd_q;

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // a new write waits until the previous response is taken
  wire wr_go = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bresp   = 2'h0;

  wire wr_cmd   = wr_go && awa_q == FSP_CMD_OFS;
  wire [2:0] cmd = wd_q[2:0];
  wire [SW-1:0] rd_sec = rdadr_q[7 -: SW];
  wire [SW-1:0] op_sec = op_q.addr[7 -: SW];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q    <= '0;
      sel_q   <= '0;
      prot_q  <= '0;
      rdadr_q <= 8'h00;
      limit_q <= FSP_LIMIT_RST;
    end else if (wr_go && s_axi_wstrb[0]) begin
      case (awa_q)
        FSP_ADDR_OFS:  op_q.addr <= wd_q[7:0];
        FSP_DATA_OFS:  op_q.data <= wd_q[7:0];
        FSP_SEL_OFS:   sel_q     <= wd_q[SECTORS-1:0];
        FSP_PROT_OFS:  prot_q    <= wd_q[SECTORS-1:0];
        FSP_RDADR_OFS: rdadr_q   <= wd_q[7:0];
        FSP_LIMIT_OFS: limit_q   <= {wd_q[15:8], wd_q[7:0]};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // embedded algorithm sequencer
  // ----------------------------------------------------------------
  wire prog_prot  = prot_q[op_sec];
  wire erase_live = |(sel_q & ~prot_q);
  wire cnt_done   = cnt_q == limit_q;
  // bits that would need 0->1 cannot be programmed: the pulse limit trips
  wire prog_bad   = |(op_q.data & ~mem_q[op_q.addr]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= FSP_IDLE;
      cnt_q  <= '0;
      tout_q <= 1'b0;
    end else begin
      // free-running; idle and suspend hold it at zero
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        FSP_IDLE, FSP_SUSP: begin
          cnt_q <= '0;
          if (wr_cmd && cmd == FSP_CMD_PROG) begin
            if (prog_prot) begin
              st_q <= FSP_PROT;                                  // RQ4 RQ15
              cnt_q <= CW'(PROT_ERASE_CYC - FSP_PROT_PROG_CYC);
            end else begin
              st_q <= (st_q == FSP_SUSP) ? FSP_SUSP_PROG : FSP_PROG;  // RQ2 RQ10
            end
          end else if (st_q == FSP_IDLE && wr_cmd &&
                       (cmd == FSP_CMD_ERASE || cmd == FSP_CMD_CHIP)) begin
            st_q <= erase_live ? FSP_ERASE : FSP_PROT;           // RQ12 RQ13
          end else if (st_q == FSP_SUSP && wr_cmd && cmd == FSP_CMD_RESUME) begin
            st_q <= FSP_ERASE;
          end
        end
        FSP_PROG, FSP_SUSP_PROG: begin
          if (prog_bad && cnt_done) begin
            st_q   <= FSP_FAIL;
            tout_q <= 1'b1;                                      // RQ22
          end else if (!prog_bad && cnt_q == CW'(FSP_PULSE_CYC)) begin
            st_q <= (st_q == FSP_SUSP_PROG) ? FSP_SUSP : FSP_IDLE;  // RQ16
          end
        end
        FSP_ERASE: begin
          if (wr_cmd && cmd == FSP_CMD_SUSPEND)
            st_q <= FSP_SUSP;                                    // RQ14
          else if (cnt_done)
            st_q <= FSP_IDLE;
        end
        FSP_PROT: begin
          if (cnt_q == CW'(PROT_ERASE_CYC - 1))
            st_q <= FSP_IDLE;
        end
        FSP_FAIL: begin
          if (wr_cmd && cmd == FSP_CMD_RESET) begin
            st_q   <= FSP_IDLE;
            tout_q <= 1'b0;
          end
        end
        default: st_q <= FSP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // array storage
  // ----------------------------------------------------------------
  wire prog_fin = (st_q == FSP_PROG || st_q == FSP_SUSP_PROG) &&
                  !prog_bad && cnt_q == CW'(FSP_PULSE_CYC);
  // a suspend landing on the last erase cycle wins
  wire erase_fin = st_q == FSP_ERASE && cnt_done && !(wr_cmd && cmd == FSP_CMD_SUSPEND);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 256; i++) mem_q[i] <= FSP_ERASED;
    end else begin
      if (prog_fin) mem_q[op_q.addr] <= op_q.data;
      if (erase_fin) begin
        for (int i = 0; i < 256; i++) begin
          if (sel_q[i[7 -: SW]] && !prot_q[i[7 -: SW]])        // RQ13
            mem_q[i] <= FSP_ERASED;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // protected program marker
  // ----------------------------------------------------------------
  // polarity in the protected wait follows the rejected datum
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_pg_q <= 1'b0;
    end else if (st_q == FSP_IDLE || st_q == FSP_SUSP) begin
      prot_pg_q <= wr_cmd && cmd == FSP_CMD_PROG && prog_prot;   // RQ4
    end
  end

  // ----------------------------------------------------------------
  // status byte and read-cycle toggling
  // ----------------------------------------------------------------
  // failed programs keep toggling until reset
  wire busy_prog  = st_q == FSP_PROG || st_q == FSP_SUSP_PROG || st_q == FSP_FAIL;
  wire in_sel     = sel_q[rd_sec];
  // suspended reads outside the selection fall through to the array
  wire show_stat  = busy_prog || st_q == FSP_ERASE || st_q == FSP_PROT ||
                    (st_q == FSP_SUSP && in_sel);                // RQ18 RQ23
  wire tog_bank   = busy_prog || st_q == FSP_ERASE || st_q == FSP_PROT;  // RQ9
  wire tog_sec    = (st_q == FSP_ERASE || st_q == FSP_SUSP) && in_sel;   // RQ17
  wire cpol       = busy_prog ? ~op_q.data[FSP_CPOL_POS] :       // RQ1
                    st_q == FSP_PROT ? prot_pg_q & ~op_q.data[FSP_CPOL_POS] :
                    st_q == FSP_SUSP;                            // RQ5
  wire [7:0] stat = {cpol, btog_q, tout_q, 2'b00, stog_q, 2'b00};
  // only poll-data reads count as flash read cycles
  wire rd_go      = s_axi_arvalid && s_axi_arready;
  wire rd_dat     = rd_go && s_axi_araddr == FSP_RDDAT_OFS;      // RQ11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btog_q  <= 1'b0;
      stog_q  <= 1'b0;
      rddat_q <= 8'h00;
    end else if (rd_dat) begin
      rddat_q <= show_stat ? stat : mem_q[rdadr_q];              // RQ7
      if (tog_bank) btog_q <= ~btog_q;
      if (tog_sec)  stog_q <= ~stog_q;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  logic [7:0] ara_q;
  wire ok_rd = ara_q <= FSP_LIMIT_OFS && ara_q[1:0] == 2'b00;
  wire [7:0] st_code = 8'(st_q);
  // status offset shows the live byte without toggling
  wire [31:0] rd_mux =
    ara_q == FSP_ADDR_OFS  ? {24'h0, op_q.addr} :
    ara_q == FSP_DATA_OFS  ? {24'h0, op_q.data} :
    ara_q == FSP_SEL_OFS   ? 32'(sel_q) :
    ara_q == FSP_PROT_OFS  ? 32'(prot_q) :
    ara_q == FSP_STAT_OFS  ? {16'h0, st_code, stat} :
    ara_q == FSP_RDADR_OFS ? {24'h0, rdadr_q} :
    ara_q == FSP_RDDAT_OFS ? {24'h0, rddat_q} :
    ara_q == FSP_LIMIT_OFS ? {16'h0, limit_q} : 32'h0;

  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rdata   = rd_mux;
  assign s_axi_rresp   = ok_rd ? 2'h0 : 2'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      ara_q <= 8'h00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      ara_q <= s_axi_araddr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : fsp_status

// File: test/fsp_host.sv
module fsp_host
  import fsp_pkg::*;
(
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  assign s_axi_wstrb  = 4'hf;
  assign s_axi_bready = 1'b1;
  assign s_axi_rready = 1'b1;
  initial begin
    s_axi_awaddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_araddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_arvalid = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : fsp_host

// File: test/fsp_chk.sv
module fsp_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  b_after_w_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  aw_block_a: assert property (wr_both |=> !s_axi_awready && !s_axi_wready)
    else $error("write channel accepted twice");
  b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  b_one_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_after_ar_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  r_one_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
  r_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
    else $error("bad read response code");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
endmodule : fsp_chk

// File: test/test_flash_write_status_polling.sv
module test_flash_write_status_polling;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, a, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          n_mismatch, checks;
  fsp_status #(.PROT_ERASE_CYC(100)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fsp_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic poll(output logic [7:0] v);
    host.rd(FSP_RDDAT_OFS, d, r);
    v = d[7:0];
  endtask : poll
  task automatic go(input logic [2:0] c);
    host.wr(FSP_CMD_OFS, {29'h0, c});
  endtask : go
  task automatic prog(input logic [7:0] ad, input logic [7:0] dt, input logic [7:0] pm);
    host.wr(FSP_PROT_OFS, {24'h0, pm});
    host.wr(FSP_RDADR_OFS, {24'h0, ad});
    host.wr(FSP_ADDR_OFS, {24'h0, ad});
    host.wr(FSP_DATA_OFS, {24'h0, dt});
    go(FSP_CMD_PROG);
  endtask : prog
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_prog();
    prog(8'h10, 8'h5a, 8'h00);
    poll(a);
    chk("prog polarity", 32'h1, a[7]);
    repeat (10) @(posedge aclk);
    poll(a);
    chk("prog result", 32'h5a, a);
  endtask : t_prog
  task automatic t_fail();
    host.wr(FSP_LIMIT_OFS, 32'h10);
    prog(8'h10, 8'hff, 8'h00);
    repeat (40) @(posedge aclk);
    poll(a);
    chk("timeout bit", 32'h1, a[5]);
    chk("timeout polarity", 32'h0, a[7]);
    poll(b);
    chk("timeout reread polarity", 32'h0, b[7]);
    chk("timeout toggle", 32'h1, a[6] ^ b[6]);
    go(FSP_CMD_RESET);
    poll(a);
    chk("data after reset", 32'h5a, a);
  endtask : t_fail
  task automatic t_erase();
    host.wr(FSP_LIMIT_OFS, {16'h0, FSP_LIMIT_RST});
    host.wr(FSP_SEL_OFS, 32'h01);
    host.wr(FSP_RDADR_OFS, 32'h00);
    go(FSP_CMD_ERASE);
    poll(a);
    poll(b);
    chk("erase polarity", 32'h0, a[7]);
    chk("erase bank toggle", 32'h1, a[6] ^ b[6]);
    chk("erase sector toggle", 32'h1, a[2] ^ b[2]);
    host.wr(FSP_RDADR_OFS, 32'he0);
    poll(a);
    poll(b);
    chk("other bank toggle", 32'h1, a[6] ^ b[6]);
    chk("other sector toggle", 32'h0, a[2] ^ b[2]);
    go(FSP_CMD_SUSPEND);
    poll(a);
    chk("suspended array", 32'hff, a);
    host.wr(FSP_RDADR_OFS, 32'h00);
    poll(a);
    poll(b);
    chk("suspend bank toggle", 32'h0, a[6] ^ b[6]);
    chk("suspend sector toggle", 32'h1, a[2] ^ b[2]);
    go(FSP_CMD_RESUME);
    repeat (300) @(posedge aclk);
    poll(a);
    poll(b);
    chk("erase done toggle", 32'h0, a[6] ^ b[6]);
    chk("erase done polarity", 32'h1, a[7]);
    host.wr(FSP_RDADR_OFS, 32'h10);
    poll(a);
    chk("erase result", 32'hff, a);
  endtask : t_erase
  task automatic t_prot();
    prog(8'h24, 8'h00, 8'h02);
    poll(a);
    poll(b);
    chk("prot prog toggle", 32'h1, a[6] ^ b[6]);
    chk("prot prog polarity", 32'h1, a[7]);
    repeat (20) @(posedge aclk);
    poll(a);
    chk("prot prog skipped", 32'hff, a);
    host.wr(FSP_SEL_OFS, 32'h02);
    go(FSP_CMD_ERASE);
    poll(a);
    poll(b);
    chk("prot erase toggle", 32'h1, a[6] ^ b[6]);
    repeat (150) @(posedge aclk);
    poll(a);
    chk("prot erase array", 32'hff, a);
    host.rd(8'h40, d, r);
    chk("unmapped resp", 32'h2, r);
    chk("unmapped data", 32'h0, d);
  endtask : t_prot
  task automatic results();
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  initial begin
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_prog();
    t_fail();
    t_erase();
    t_prot();
    results();
  end
endmodule : test_flash_write_status_polling
bind fsp_status fsp_chk chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
